// ===== hdl/ced_pkg.sv
// ****************************************************************
// constants and carriers of the comparator edge control block
// ****************************************************************
package ced_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W   = 10;   // byte address width
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned REG_W    = 8;    // registers sit in the low byte
  localparam int unsigned IDX_LSB  = 2;    // byte address = 4 * index

  // register indices
  localparam logic [7:0] IDX_DEBOUNCE   = 8'h9a;
  localparam logic [7:0] IDX_UNIT0_MODE = 8'h9c;
  localparam logic [7:0] IDX_UNIT1_MODE = 8'ha0;
  localparam logic [7:0] IDX_IRQ_CTRL   = 8'ha1;
  localparam logic [7:0] IDX_TIMER_CTRL = 8'ha2;

  localparam logic [REG_W-1:0]  REG_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // both mode registers
  localparam int unsigned MODE_EN  = 7;
  localparam int unsigned MODE_OEN = 6;
  localparam int unsigned MODE_OUT = 5;
  localparam int unsigned MODE_SF  = 4;
  localparam int unsigned MODE_G   = 3;
  localparam int unsigned SRC_LSB  = 0;    // unit 1 positive source, 3 bits
  localparam int unsigned SRC_W    = 3;
  localparam logic [SRC_W-1:0] SRC_PIN = 3'h0;  // positive input from its pin

  // de-bounce register
  localparam int unsigned DLY_W      = 4;
  localparam int unsigned DB_U0_LSB  = 0;
  localparam int unsigned DB_U1_LSB  = 4;

  // interrupt control register
  localparam int unsigned IRQ_U0_FLAG = 0;
  localparam int unsigned IRQ_U0_EN   = 1;
  localparam int unsigned IRQ_U1_FLAG = 2;
  localparam int unsigned IRQ_U1_EN   = 3;

  // timer control register
  localparam int unsigned TMR_POE = 0;
  localparam int unsigned TMR_EN  = 1;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CNT_W        = 6;  // holds up to 30 delay cycles
  localparam int unsigned DIV_W        = 8;
  localparam int unsigned CPU_DIV_DEF  = 4;  // cpu clock = oscillator / 4

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic positive_analog;  // positive pin taken from gpio
    logic negative_analog;  // negative pin taken from gpio
    logic out_oe;           // output pin driven by the comparator
    logic out;              // level driven onto the output pin
  } ced_pin_s;

  typedef struct packed {
    logic enable;
    logic output_pin_enable;
    logic special_mode;
    logic edge_select;
  } ced_mode_s;

  typedef struct packed {
    logic             level;
    logic [CNT_W-1:0] cnt;
  } ced_filter_s;

  typedef struct packed {
    logic              bus_wait;
    logic [DATA_W-1:0] readdata;
    ced_mode_s         mode0;
    ced_mode_s         mode1;
    logic [SRC_W-1:0]  src1;
    logic [DLY_W-1:0]  dly0;
    logic [DLY_W-1:0]  dly1;
    logic              flag0;
    logic              ien0;
    logic              flag1;
    logic              ien1;
    logic              poe;
    logic              ten;
    ced_filter_s       filt0;
    ced_filter_s       filt1;
    logic [DIV_W-1:0]  div;
    logic              irq0;
    logic              irq1;
    logic              trig;
    logic              stop;
    ced_pin_s          pins0;
    ced_pin_s          pins1;
    logic [SRC_W-1:0]  ref_sel;
  } ced_state_s;

endpackage

// ===== hdl/ced_comparator_edge_control.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module ced_comparator_edge_control #(
  parameter int unsigned CPU_DIV = ced_pkg::CPU_DIV_DEF  // oscillator cycles per cpu cycle
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // avalon-mm slave
  input  wire logic [ced_pkg::ADDR_W-1:0]    address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [ced_pkg::DATA_W-1:0]    writedata,
  input  wire logic [3:0]                    byteenable,
  output logic      [ced_pkg::DATA_W-1:0]    readdata,
  output logic                               waitrequest,
  // raw comparator results from the analog cores
  input  wire logic                          unit0_result,
  input  wire logic                          unit1_result,
  // pin steering towards the pad ring and analog cores
  output ced_pkg::ced_pin_s                  unit0_pins,
  output ced_pkg::ced_pin_s                  unit1_pins,
  output logic      [ced_pkg::SRC_W-1:0]     unit1_reference_select,
  // pulse timer control
  output logic                               pulse_trigger,
  output logic                               pulse_stop,
  output logic                               pulse_output_enable,
  output logic                               timer_enable,
  // interrupt requests towards the processor
  output logic                               unit0_interrupt_request,
  output logic                               unit1_interrupt_request
);

  // ****************************************************************
  // de-bounce step
  // ****************************************************************
  // the counter runs only while the raw level differs from the passed one;
  // any bounce back to the passed level restarts the wait from zero
  function automatic ced_pkg::ced_filter_s filt_step(
    input ced_pkg::ced_filter_s        f,
    input logic                        raw,
    input logic                        en,
    input logic                        tick,
    input logic [ced_pkg::CNT_W-1:0]   target
  );
    ced_pkg::ced_filter_s n;
    n = f;
    if (!en) begin
      // off: forget level and count
      n.level = 1'b0;
      n.cnt   = '0;
    end else if (raw == f.level) begin
      // bounce or no change restarts
      n.cnt = '0;
    end else if (target == '0) begin
      // no delay: pass at once
      n.level = raw;
      n.cnt   = '0;
    end else if (f.cnt >= target) begin
      // stable long enough
      n.level = raw;
      n.cnt   = '0;
    end else if (tick) begin
      // unit 1 counts only on ticks
      n.cnt = f.cnt + 1'b1;
    end
    return n;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  ced_pkg::ced_state_s state;
  ced_pkg::ced_state_s next_state;

  // bus decode
  logic [7:0]                 word_idx;
  logic                       hit_db;
  logic                       hit_m0;
  logic                       hit_m1;
  logic                       hit_irq;
  logic                       hit_tmr;
  logic                       wr_now;
  logic [ced_pkg::REG_W-1:0]  wbyte;
  logic [ced_pkg::REG_W-1:0]  rbyte;

  // delay timing; the divider wraps on the tick, at CPU_DIV - 1
  localparam int unsigned     DIV_LAST = CPU_DIV - 1;
  logic                       cpu_tick;
  logic [ced_pkg::CNT_W-1:0]  target0;
  logic [ced_pkg::CNT_W-1:0]  target1;

  // events on the delayed levels
  logic                       rise0;
  logic                       fall0;
  logic                       rise1;
  logic                       fall1;
  logic                       edge0;
  logic                       edge1;

  // actions decided this cycle
  logic                       stop_now;
  logic                       flag0_clr;
  logic                       flag1_clr;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // bits below the word index are ignored; only the low byte lane carries data
  assign word_idx = address[ced_pkg::IDX_LSB +: 8];
  assign hit_db   = (word_idx == ced_pkg::IDX_DEBOUNCE);
  assign hit_m0   = (word_idx == ced_pkg::IDX_UNIT0_MODE);
  assign hit_m1   = (word_idx == ced_pkg::IDX_UNIT1_MODE);
  assign hit_irq  = (word_idx == ced_pkg::IDX_IRQ_CTRL);
  assign hit_tmr  = (word_idx == ced_pkg::IDX_TIMER_CTRL);
  // upper write lanes are ignored
  assign wbyte    = writedata[ced_pkg::REG_W-1:0];
  // a write lands on the edge where waitrequest is seen low
  assign wr_now   = write && !state.bus_wait && byteenable[0];

  // ****************************************************************
  // cpu clock tick and delay targets
  // ****************************************************************
  // unit 1 counts cpu cycles, derived from the oscillator-rate system clock
  assign cpu_tick = (state.div == DIV_LAST[ced_pkg::DIV_W-1:0]);
  // unit 0 waits N cycles, unit 1 waits 2N cpu ticks
  assign target0  = {2'b00, state.dly0};
  assign target1  = {1'b0, state.dly1, 1'b0};

  // with CPU_DIV at 1 every edge is a cpu tick

  // ****************************************************************
  // read mux
  // ****************************************************************
  // output flags show the raw result, so software sees it before the delay
  // unmapped indices read as zero
  always_comb begin
    rbyte = ced_pkg::REG_RESET;
    if (hit_db) begin
      // both delay nibbles
      rbyte[ced_pkg::DB_U0_LSB +: ced_pkg::DLY_W] = state.dly0;
      rbyte[ced_pkg::DB_U1_LSB +: ced_pkg::DLY_W] = state.dly1;
    end else if (hit_m0) begin
      // unit 0 mode, flag gated by enable
      rbyte[ced_pkg::MODE_EN]  = state.mode0.enable;
      rbyte[ced_pkg::MODE_OEN] = state.mode0.output_pin_enable;
      rbyte[ced_pkg::MODE_OUT] = unit0_result & state.mode0.enable;
      rbyte[ced_pkg::MODE_SF]  = state.mode0.special_mode;
      rbyte[ced_pkg::MODE_G]   = state.mode0.edge_select;
    end else if (hit_m1) begin
      // unit 1 mode and source
      rbyte[ced_pkg::MODE_EN]  = state.mode1.enable;
      rbyte[ced_pkg::MODE_OEN] = state.mode1.output_pin_enable;
      rbyte[ced_pkg::MODE_OUT] = unit1_result & state.mode1.enable;
      rbyte[ced_pkg::MODE_SF]  = state.mode1.special_mode;
      rbyte[ced_pkg::MODE_G]   = state.mode1.edge_select;
      rbyte[ced_pkg::SRC_LSB +: ced_pkg::SRC_W] = state.src1;
    end else if (hit_irq) begin
      // flags and enables
      rbyte[ced_pkg::IRQ_U0_FLAG] = state.flag0;
      rbyte[ced_pkg::IRQ_U0_EN]   = state.ien0;
      rbyte[ced_pkg::IRQ_U1_FLAG] = state.flag1;
      rbyte[ced_pkg::IRQ_U1_EN]   = state.ien1;
    end else if (hit_tmr) begin
      // pulse timer control
      rbyte[ced_pkg::TMR_POE] = state.poe;
      rbyte[ced_pkg::TMR_EN]  = state.ten;
    end
  end

  // ****************************************************************
  // cpu divider, de-bounce and edge detection on the delayed levels
  // ****************************************************************
  always_comb begin
    next_state = state;

    // cpu divider runs freely
    // its count only matters to unit 1
    if (cpu_tick) begin
      next_state.div = '0;
    end else begin
      next_state.div = state.div + 1'b1;
    end

    // de-bounce both units; a disabled unit holds its level and count at zero
    // unit 0 counts every clock, unit 1 cpu ticks
    next_state.filt0 = filt_step(state.filt0, unit0_result, state.mode0.enable, 1'b1, target0);
    next_state.filt1 = filt_step(state.filt1, unit1_result, state.mode1.enable, cpu_tick, target1);
  end

  // edges compare old and new passed level, never the raw input
  // gated by the enable: switching off drops the level, which is no event
  assign rise0 = state.mode0.enable && !state.filt0.level && next_state.filt0.level;
  assign fall0 = state.mode0.enable && state.filt0.level && !next_state.filt0.level;
  assign rise1 = state.mode1.enable && !state.filt1.level && next_state.filt1.level;
  assign fall1 = state.mode1.enable && state.filt1.level && !next_state.filt1.level;
  // the edge select picks which direction counts
  assign edge0 = state.mode0.edge_select ? rise0 : fall0;
  assign edge1 = state.mode1.edge_select ? rise1 : fall1;
  // the stop only acts while pulses are being produced
  assign stop_now = edge1 && state.mode1.special_mode && state.poe;

  // software clears a flag by writing zero to its bit
  // writing one leaves a flag alone
  assign flag0_clr = wr_now && hit_irq && !wbyte[ced_pkg::IRQ_U0_FLAG];
  assign flag1_clr = wr_now && hit_irq && !wbyte[ced_pkg::IRQ_U1_FLAG];

  // ****************************************************************
  // register file, events and outputs
  // ****************************************************************
  ced_pkg::ced_state_s upd;

  always_comb begin
    upd = next_state;

    // bus handshake: one wait cycle, then answer for one cycle
    // the master must release right after the answer
    if (state.bus_wait && (read || write)) begin
      upd.bus_wait = 1'b0;
      upd.readdata = ced_pkg::DATA_ZERO;
      if (read) begin
        upd.readdata[ced_pkg::REG_W-1:0] = rbyte;
      end
    end else begin
      upd.bus_wait = 1'b1;
    end

    // software writes
    if (wr_now && hit_db) begin
      upd.dly0 = wbyte[ced_pkg::DB_U0_LSB +: ced_pkg::DLY_W];
      upd.dly1 = wbyte[ced_pkg::DB_U1_LSB +: ced_pkg::DLY_W];
    end

    // unit 0 mode; the flag bit is not stored
    if (wr_now && hit_m0) begin
      upd.mode0.enable            = wbyte[ced_pkg::MODE_EN];
      upd.mode0.output_pin_enable = wbyte[ced_pkg::MODE_OEN];
      upd.mode0.special_mode      = wbyte[ced_pkg::MODE_SF];
      upd.mode0.edge_select       = wbyte[ced_pkg::MODE_G];
    end

    // unit 1 mode and source
    if (wr_now && hit_m1) begin
      upd.mode1.enable            = wbyte[ced_pkg::MODE_EN];
      upd.mode1.output_pin_enable = wbyte[ced_pkg::MODE_OEN];
      upd.mode1.special_mode      = wbyte[ced_pkg::MODE_SF];
      upd.mode1.edge_select       = wbyte[ced_pkg::MODE_G];
      upd.src1 = wbyte[ced_pkg::SRC_LSB +: ced_pkg::SRC_W];
    end

    // interrupt enables; flags below
    if (wr_now && hit_irq) begin
      upd.ien0 = wbyte[ced_pkg::IRQ_U0_EN];
      upd.ien1 = wbyte[ced_pkg::IRQ_U1_EN];
    end

    // pulse timer control
    if (wr_now && hit_tmr) begin
      upd.poe = wbyte[ced_pkg::TMR_POE];
      upd.ten = wbyte[ced_pkg::TMR_EN];
    end

    // flags: the set comes after the clear so a same-cycle event survives;
    // flags latch with or without their enables
    if (flag0_clr) begin
      upd.flag0 = 1'b0;
    end
    if (edge0) begin
      upd.flag0 = 1'b1;
    end

    // unit 1 flag, same order
    if (flag1_clr) begin
      upd.flag1 = 1'b0;
    end
    if (edge1) begin
      upd.flag1 = 1'b1;
    end

    // hardware stop overrides a software write in the same cycle
    // unit 0 and unit 1 special modes drop too; software re-arms
    if (stop_now) begin
      upd.poe                = 1'b0;
      upd.ten                = 1'b0;
      upd.mode0.special_mode = 1'b0;
      upd.mode1.special_mode = 1'b0;
    end

    // timer pulses, one cycle each
    // the trigger ignores the pulse enable
    upd.trig = edge0 && state.mode0.special_mode;
    upd.stop = stop_now;

    // interrupt requests follow the flags gated by their enables
    // they fall only on a software write: a flag clear or an enable written to zero
    upd.irq0 = upd.flag0 && upd.ien0;
    upd.irq1 = upd.flag1 && upd.ien1;

    // pin steering: a disabled unit gives every pin back to gpio
    upd.pins0.positive_analog = upd.mode0.enable;
    upd.pins0.negative_analog = upd.mode0.enable;
    upd.pins0.out_oe  = upd.mode0.enable && upd.mode0.output_pin_enable;
    upd.pins0.out     = unit0_result && upd.mode0.enable;

    // unit 1 positive pin only when the source is the pin
    upd.pins1.positive_analog = upd.mode1.enable && (upd.src1 == ced_pkg::SRC_PIN);
    upd.pins1.negative_analog = upd.mode1.enable;
    upd.pins1.out_oe  = upd.mode1.enable && upd.mode1.output_pin_enable;
    upd.pins1.out     = unit1_result && upd.mode1.enable;
    // internal reference is only connected while the unit runs
    upd.ref_sel = upd.mode1.enable ? upd.src1 : ced_pkg::SRC_PIN;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // every field moves on every edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // the bus idles with waitrequest high
      state          <= '0;
      state.bus_wait <= 1'b1;
    end else begin
      state <= upd;
    end
  end

  // ****************************************************************
  // outputs straight from the state register
  // ****************************************************************
  assign readdata                = state.readdata;
  assign waitrequest             = state.bus_wait;

  // pin steering
  assign unit0_pins              = state.pins0;
  assign unit1_pins              = state.pins1;
  assign unit1_reference_select  = state.ref_sel;

  // timer controls and requests
  assign pulse_trigger           = state.trig;
  assign pulse_stop              = state.stop;
  assign pulse_output_enable     = state.poe;
  assign timer_enable            = state.ten;
  assign unit0_interrupt_request = state.irq0;
  assign unit1_interrupt_request = state.irq1;

endmodule

`default_nettype wire

// ===== sim/ced_comparator_edge_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checks
// ****************
module ced_comparator_edge_control_sva #(
  parameter int unsigned CPU_DIV = 4
) (
  // clock and reset
  input wire logic                       clock,
  input wire logic                       sys_rst,
  // bus handshake
  input wire logic                       read,
  input wire logic                       write,
  input wire logic                       waitrequest,
  // comparator side
  input wire logic                       unit0_result,
  input wire ced_pkg::ced_pin_s          unit0_pins,
  input wire ced_pkg::ced_pin_s          unit1_pins,
  input wire logic [ced_pkg::SRC_W-1:0]  unit1_reference_select,
  // timer and interrupts
  input wire logic                       pulse_trigger,
  input wire logic                       pulse_stop,
  input wire logic                       pulse_output_enable,
  input wire logic                       timer_enable,
  input wire logic                       unit0_interrupt_request,
  input wire logic                       unit1_interrupt_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // a request taken while idle is answered for exactly one cycle
  sequence s_taken; (read || write) && waitrequest; endsequence
  sequence s_answer; !waitrequest ##1 waitrequest; endsequence
  property p_answer; s_taken |=> s_answer; endproperty
  property p_trig_once; pulse_trigger |=> !pulse_trigger; endproperty
  // without a bus write nothing may drop a latched request
  property p_irq0_hold; unit0_interrupt_request && !write |=> unit0_interrupt_request; endproperty
  property p_irq1_hold; unit1_interrupt_request && !write |=> unit1_interrupt_request; endproperty
  property p_stop_clears; pulse_stop |-> !pulse_output_enable && !timer_enable; endproperty
  property p_stop_armed; pulse_stop |-> $past(pulse_output_enable); endproperty
  property p_gpio0; !unit0_pins.negative_analog |-> !unit0_pins.positive_analog && !unit0_pins.out_oe; endproperty
  property p_gpio1;
    !unit1_pins.negative_analog |-> unit1_reference_select == 3'h0 && !unit1_pins.positive_analog && !unit1_pins.out_oe;
  endproperty
  property p_pos1; unit1_pins.positive_analog |-> unit1_reference_select == 3'h0; endproperty
  property p_out0; unit0_pins.out_oe && $past(unit0_pins.out_oe) |-> unit0_pins.out == $past(unit0_result); endproperty

  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  a_trig_once: assert property (p_trig_once) else $error("trigger longer than one cycle");
  a_irq0_hold: assert property (p_irq0_hold) else $error("unit0 request dropped");
  a_irq1_hold: assert property (p_irq1_hold) else $error("unit1 request dropped");
  a_stop_clears: assert property (p_stop_clears) else $error("stop left timer on");
  a_stop_armed: assert property (p_stop_armed) else $error("stop without pulse enable");
  a_gpio0: assert property (p_gpio0) else $error("unit0 pins not gpio");
  a_gpio1: assert property (p_gpio1) else $error("unit1 pins not gpio");
  a_pos1: assert property (p_pos1) else $error("positive pin with reference");
  a_out0: assert property (p_out0) else $error("unit0 pin not result");
endmodule

bind ced_comparator_edge_control ced_comparator_edge_control_sva #(.CPU_DIV(CPU_DIV)) u_sva (
  .clock(clock), .sys_rst(sys_rst), .read(read), .write(write), .waitrequest(waitrequest),
  .unit0_result(unit0_result), .unit0_pins(unit0_pins), .unit1_pins(unit1_pins),
  .unit1_reference_select(unit1_reference_select), .pulse_trigger(pulse_trigger), .pulse_stop(pulse_stop),
  .pulse_output_enable(pulse_output_enable), .timer_enable(timer_enable),
  .unit0_interrupt_request(unit0_interrupt_request), .unit1_interrupt_request(unit1_interrupt_request)
);
`default_nettype wire

// ===== sim/ced_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// analog comparator cores
// ****************
module ced_analog_model (
  // clock
  input wire logic        clock,
  // terminal voltages as codes
  input wire logic [7:0]  pos0,
  input wire logic [7:0]  neg0,
  input wire logic [7:0]  pos1,
  input wire logic [7:0]  neg1,
  // raw results
  output var logic        unit0_result = 1'b0,
  output var logic        unit1_result = 1'b0
);
  // high only while positive exceeds negative; resolved once per clock
  always @(posedge clock) begin
    unit0_result <= pos0 > neg0;
    unit1_result <= pos1 > neg1;
  end
endmodule
`default_nettype wire

// ===== sim/ced_comparator_edge_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module ced_comparator_edge_control_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [ced_pkg::ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h1;
  logic [ced_pkg::DATA_W-1:0] writedata = '0;
  logic [ced_pkg::DATA_W-1:0] readdata;
  logic waitrequest, unit0_result, unit1_result, pulse_trigger, pulse_stop, poe, ten, irq0, irq1;
  ced_pkg::ced_pin_s unit0_pins, unit1_pins;
  logic [2:0] ref_sel;
  logic [7:0] pos0 = 8'h00, pos1 = 8'h00, rd;
  int fails = 0;
  int compares = 0;

  always #5 clock = ~clock;

  ced_analog_model u_ced_analog_model (.clock(clock), .pos0(pos0), .neg0(8'h80), .pos1(pos1), .neg1(8'h80),
    .unit0_result(unit0_result), .unit1_result(unit1_result));
  // fast cpu divider keeps unit1 counts short
  ced_comparator_edge_control #(.CPU_DIV(1)) u_ced_comparator_edge_control (.clock(clock), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .unit0_result(unit0_result), .unit1_result(unit1_result),
    .unit0_pins(unit0_pins), .unit1_pins(unit1_pins), .unit1_reference_select(ref_sel),
    .pulse_trigger(pulse_trigger), .pulse_stop(pulse_stop), .pulse_output_enable(poe), .timer_enable(ten),
    .unit0_interrupt_request(irq0), .unit1_interrupt_request(irq1));

  task automatic print_verdict;
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  // one bus cycle; an extra edge after release so the next call never retimes a strobe
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, wd};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata[7:0];
    if (n >= 50) begin
      fails++;
      print_verdict();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  // 0 unit0 request, 1 trigger pulse, 2 stop pulse
  task automatic wait_ev(input int which, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((which == 0 ? irq0 : which == 1 ? pulse_trigger : pulse_stop) !== 1'b1 && n < lim);
    if (n >= lim) begin
      fails++;
      print_verdict();
    end
  endtask

  task automatic t_regs;
    bus(1'b0, ced_pkg::IDX_DEBOUNCE, 8'h00); chk("debounce reset", 8'h00, rd);
    bus(1'b1, ced_pkg::IDX_DEBOUNCE, 8'ha5);
    byteenable <= 4'h0;
    bus(1'b1, ced_pkg::IDX_DEBOUNCE, 8'h11);
    byteenable <= 4'h1;
    bus(1'b0, ced_pkg::IDX_DEBOUNCE, 8'h00); chk("debounce", 8'ha5, rd);
    bus(1'b1, ced_pkg::IDX_UNIT0_MODE, 8'h20);
    bus(1'b0, ced_pkg::IDX_UNIT0_MODE, 8'h00); chk("unit0 mode", 8'h00, rd);
    bus(1'b0, 8'h10, 8'h00); chk("unmapped", 8'h00, rd);
  endtask

  task automatic t_unit0;
    int n;
    bus(1'b1, ced_pkg::IDX_DEBOUNCE, 8'h03);
    bus(1'b1, ced_pkg::IDX_IRQ_CTRL, 8'h02);
    bus(1'b1, ced_pkg::IDX_UNIT0_MODE, 8'hc8);
    pos0 <= 8'hff;
    repeat (3) @(posedge clock);
    pos0 <= 8'h00;
    repeat (12) @(posedge clock);
    chk("glitch irq", 1'b0, irq0);
    pos0 <= 8'hff;
    wait_ev(0, 20, n); chk("rise delay", 6, n);
    bus(1'b0, ced_pkg::IDX_UNIT0_MODE, 8'h00); chk("unit0 flag", 8'he8, rd);
    chk("unit0 pins", 4'hf, unit0_pins);
    bus(1'b1, ced_pkg::IDX_IRQ_CTRL, 8'h02);
    @(posedge clock); chk("irq cleared", 1'b0, irq0);
    bus(1'b1, ced_pkg::IDX_UNIT0_MODE, 8'hd0);
    pos0 <= 8'h00;
    wait_ev(1, 20, n); chk("trigger delay", 6, n);
    @(posedge clock); chk("trigger irq", 1'b1, irq0);
    bus(1'b1, ced_pkg::IDX_UNIT0_MODE, 8'h00);
    @(posedge clock); chk("unit0 off", 4'h0, unit0_pins);
  endtask

  task automatic t_unit1;
    int n;
    pos1 <= 8'hff;
    bus(1'b1, ced_pkg::IDX_DEBOUNCE, 8'h10);
    bus(1'b1, ced_pkg::IDX_UNIT0_MODE, 8'h10);
    bus(1'b1, ced_pkg::IDX_TIMER_CTRL, 8'h03);
    bus(1'b1, ced_pkg::IDX_IRQ_CTRL, 8'h08);
    bus(1'b1, ced_pkg::IDX_UNIT1_MODE, 8'h93);
    chk("reference", 3'h3, ref_sel);
    chk("unit1 pins", 4'h5, unit1_pins);
    bus(1'b0, ced_pkg::IDX_UNIT1_MODE, 8'h00); chk("unit1 mode", 8'hb3, rd);
    repeat (10) @(posedge clock);
    chk("rise ignored", 1'b0, irq1);
    pos1 <= 8'h00;
    wait_ev(2, 30, n); chk("stop delay", 5, n);
    @(posedge clock); chk("timer stopped", 2'b00, {poe, ten});
    chk("unit1 irq", 1'b1, irq1);
    bus(1'b0, ced_pkg::IDX_UNIT0_MODE, 8'h00); chk("unit0 special", 8'h00, rd & 8'h10);
    repeat (20) @(posedge clock);
    chk("irq held", 1'b1, irq1);
    bus(1'b1, ced_pkg::IDX_IRQ_CTRL, 8'h08);
    @(posedge clock); chk("irq1 cleared", 1'b0, irq1);
    bus(1'b1, ced_pkg::IDX_TIMER_CTRL, 8'h03); chk("rearm", 2'b11, {poe, ten});
  endtask

  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_unit0();
    t_unit1();
    print_verdict();
  end
endmodule
`default_nettype wire
